// ==== shared/omtc_pkg.sv ====
// Summary of operation
// (RL1) exactly one of three operating modes runs
// (RL2) four second initialization before normal operation
// (RL3) normal operation held until reset; the code also leaves it for the console on byte 03
// (RL4) banner sent unless quiet setting is on
// (RL5) banner reports power, software or external cause
// (RL6) console during init forces autonomous, shown later
// (RL7) one mode message at init end unless quiet
// (RL8) autonomous mode keeps network link disabled
// (RL9) autonomous default free-running frames on both outputs
// (RL10) commands on rs232, rs422 only if full duplex
// (RL11) single byte commands, never echoed
// (RL12) byte 03 enters command console
// (RL13) byte 13 selects polled telemetry
// (RL14) polled 0d or 20 gives one frame
// (RL15) byte 01 resumes free-running telemetry
// (RL16) byte 10 powers sensors down, mutes telemetry
// (RL17) byte 15 repowers sensors, resumes telemetry
// (RL18) byte 12 resets after delay, cause software
// (RL19) repeated commands change nothing except frame requests
// (RL20) free-running paced by maximum frame rate setting
// (RL21) networked only if enabled and master attached
// (RL22) master needs three enables and slaves attached
// (RL23) unknown bytes are ignored
// (RL24) start free-running with sensors powered
package omtc_pkg;
  // =====================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INIT_TIME_S = 4;
  localparam int unsigned REBOOT_DELAY_S = 3;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned INIT_CYCLES = INIT_TIME_S * (NS_PER_S / CLK_PERIOD_NS);
  localparam int unsigned REBOOT_CYCLES = REBOOT_DELAY_S * (NS_PER_S / CLK_PERIOD_NS);
  localparam int unsigned CNT_W = 32;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned BYTE_W = 8;
  // =====================================
  // command codes
  localparam logic [7:0] CMD_CONSOLE = 8'h03;
  localparam logic [7:0] CMD_POLL = 8'h13;
  localparam logic [7:0] CMD_ENTER = 8'h0D;
  localparam logic [7:0] CMD_SPACE = 8'h20;
  localparam logic [7:0] CMD_FREE = 8'h01;
  localparam logic [7:0] CMD_PWR_DN = 8'h10;
  localparam logic [7:0] CMD_PWR_UP = 8'h15;
  localparam logic [7:0] CMD_RESET = 8'h12;
  // =====================================
  // encodings
  localparam logic [1:0] CAUSE_POWER = 2'h0;
  localparam logic [1:0] CAUSE_SOFT = 2'h1;
  localparam logic [1:0] CAUSE_EXT = 2'h2;
  localparam logic [1:0] MSG_BANNER = 2'h0;
  localparam logic [1:0] MSG_MODE = 2'h1;
  localparam logic [2:0] MODE_RESET = 3'h1;
  typedef enum logic [2:0] {
    OMTC_AUTO = 3'b001,
    OMTC_NET = 3'b010,
    OMTC_MASTER = 3'b100
  } omtc_mode_t;
  typedef enum logic [3:0] {
    OMTC_ST_INIT = 4'b0001,
    OMTC_ST_RUN = 4'b0010,
    OMTC_ST_CONSOLE = 4'b0100,
    OMTC_ST_REBOOT = 4'b1000
  } omtc_state_t;
endpackage

// ==== logic/omtc_fifo.sv ====
`timescale 1ns/100ps
module omtc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== logic/omtc_top.sv ====
`timescale 1ns/100ps
module omtc_top #(
  parameter int unsigned INIT_CNT = omtc_pkg::INIT_CYCLES,
  parameter int unsigned REBOOT_CNT = omtc_pkg::REBOOT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ext_reset_seen,
  input wire logic i_quiet,
  input wire logic i_net_en,
  input wire logic i_master_en,
  input wire logic i_bias_en,
  input wire logic i_master_attached,
  input wire logic i_slaves_attached,
  input wire logic i_rs422_full_duplex,
  input wire logic [omtc_pkg::CNT_W-1:0] i_frame_period,
  input wire logic i_rs232_valid,
  input wire logic [7:0] i_rs232_data,
  input wire logic i_rs422_valid,
  input wire logic [7:0] i_rs422_data,
  output logic o_cmd_ready,
  input wire logic i_frame_done,
  output logic o_frame_req,
  output logic o_frame_rs232_en,
  output logic o_frame_rs422_en,
  output logic o_msg_req,
  output logic [1:0] o_msg_kind,
  output logic [1:0] o_reset_cause,
  output logic o_normal,
  output logic [2:0] o_mode,
  output logic o_net_link_en,
  output logic o_console,
  output logic o_polled,
  output logic o_sensor_pwr,
  output logic o_sys_reset
);
  import omtc_pkg::*;
  // =====================================
  // command intake, fifo absorbs bursts while a frame is being sent
  logic f_valid;
  logic [7:0] f_data;
  logic f_ready;
  wire rx_ok_422 = i_rs422_valid && i_rs422_full_duplex; // RL10
  wire in_valid = i_rs232_valid || rx_ok_422; // RL10
  wire [7:0] in_data = i_rs232_valid ? i_rs232_data : i_rs422_data;
  omtc_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(in_valid),
    .o_in_ready(o_cmd_ready),
    .i_in_data(in_data),
    .o_out_valid(f_valid),
    .i_out_ready(f_ready),
    .o_out_data(f_data)
  );
  // =====================================
  // state
  omtc_state_t st_ff, nxt_st;
  logic [CNT_W-1:0] tmr_ff;
  logic [CNT_W-1:0] pace_ff;
  logic polled_ff;
  logic pwr_ff;
  logic busy_ff;
  logic con_req_ff;
  logic banner_sent_ff;
  logic soft_ff;
  logic [1:0] cause_ff;
  omtc_mode_t mode_ff;
  logic frame_req_ff;
  logic msg_req_ff;
  logic [1:0] msg_kind_ff;
  logic sys_reset_ff;
  // =====================================
  // decode
  wire in_init = (st_ff == OMTC_ST_INIT);
  wire in_run = (st_ff == OMTC_ST_RUN);
  // a frame in flight stalls command pops so a poll never gets lost
  assign f_ready = !busy_ff && (in_init || in_run);
  wire take = f_valid && f_ready; // RL23
  wire c_con = take && (f_data == CMD_CONSOLE); // RL12
  wire c_poll = take && (f_data == CMD_POLL); // RL13
  wire c_req = take && ((f_data == CMD_ENTER) || (f_data == CMD_SPACE)); // RL14
  wire c_free = take && (f_data == CMD_FREE); // RL15
  wire c_dn = take && (f_data == CMD_PWR_DN); // RL16
  wire c_up = take && (f_data == CMD_PWR_UP); // RL17
  wire c_rst = take && (f_data == CMD_RESET); // RL18
  wire init_end = in_init && (tmr_ff == CNT_W'(INIT_CNT - 1)); // RL2
  wire net_ok = i_net_en && i_master_attached; // RL21
  wire mst_ok = i_net_en && i_master_en && i_bias_en && i_slaves_attached; // RL22
  wire force_auto = con_req_ff || c_con; // RL6
  wire pace_hit = (pace_ff >= i_frame_period); // RL20
  wire tele_on = in_run && pwr_ff && (mode_ff != OMTC_NET); // RL16
  wire free_fire = tele_on && !polled_ff && pace_hit && !busy_ff; // RL20
  wire poll_fire = tele_on && polled_ff && c_req; // RL14
  wire fire = free_fire || poll_fire;
  wire send_banner = in_init && !banner_sent_ff && !i_quiet; // RL4
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      OMTC_ST_INIT: if (init_end) nxt_st = force_auto ? OMTC_ST_CONSOLE : OMTC_ST_RUN; // RL6
      OMTC_ST_RUN: begin
        if (c_rst) nxt_st = OMTC_ST_REBOOT; // RL18
        else if (c_con) nxt_st = OMTC_ST_CONSOLE; // RL12
      end
      OMTC_ST_CONSOLE: nxt_st = OMTC_ST_CONSOLE;
      OMTC_ST_REBOOT: if (tmr_ff == CNT_W'(REBOOT_CNT - 1)) nxt_st = OMTC_ST_INIT; // RL18
      default: nxt_st = OMTC_ST_INIT;
    endcase
  end
  // =====================================
  // sequencing; normal operation only leaves on reset, reboot command or console command
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_ff <= OMTC_ST_INIT;
      tmr_ff <= '0;
      banner_sent_ff <= 1'b0;
      con_req_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; // RL3
      tmr_ff <= (nxt_st != st_ff) ? '0 : tmr_ff + 1'b1; // RL2
      banner_sent_ff <= in_init ? (banner_sent_ff || send_banner) : 1'b0;
      con_req_ff <= in_init ? (con_req_ff || c_con) : 1'b0; // RL6
    end
  end
  // reset cause survives the soft reboot since it is kept in fabric
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      soft_ff <= 1'b0;
      cause_ff <= CAUSE_POWER;
    end else begin
      if (st_ff == OMTC_ST_REBOOT) soft_ff <= 1'b1;
      if (init_end) soft_ff <= 1'b0;
      if (in_init && tmr_ff == '0) begin
        cause_ff <= soft_ff ? CAUSE_SOFT : (i_ext_reset_seen ? CAUSE_EXT : CAUSE_POWER); // RL5
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mode_ff <= OMTC_AUTO;
    end else if (init_end) begin
      if (force_auto) mode_ff <= OMTC_AUTO; // RL6
      else if (mst_ok) mode_ff <= OMTC_MASTER; // RL22
      else if (net_ok) mode_ff <= OMTC_NET; // RL21
      else mode_ff <= OMTC_AUTO; // RL1
    end
  end
  // =====================================
  // telemetry sub-modes; repeats are idempotent, unknown bytes fall through
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || st_ff == OMTC_ST_REBOOT) begin
      polled_ff <= 1'b0; // RL24
      pwr_ff <= 1'b1; // RL24
    end else begin
      if (c_poll) polled_ff <= 1'b1; // RL19
      if (c_free) polled_ff <= 1'b0; // RL15
      if (c_dn) pwr_ff <= 1'b0; // RL16
      if (c_up) pwr_ff <= 1'b1; // RL17
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      busy_ff <= 1'b0;
      pace_ff <= '0;
      frame_req_ff <= 1'b0;
    end else begin
      frame_req_ff <= fire;
      if (fire) busy_ff <= 1'b1;
      else if (i_frame_done) busy_ff <= 1'b0;
      pace_ff <= free_fire ? CNT_W'(1) : (pace_hit ? pace_ff : pace_ff + 1'b1); // RL20
    end
  end
  // =====================================
  // text messages
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      msg_req_ff <= 1'b0;
      msg_kind_ff <= MSG_BANNER;
      sys_reset_ff <= 1'b0;
    end else begin
      msg_req_ff <= send_banner || (init_end && !i_quiet); // RL7
      if (send_banner) msg_kind_ff <= MSG_BANNER; // RL4
      else if (init_end) msg_kind_ff <= MSG_MODE; // RL7
      sys_reset_ff <= (st_ff == OMTC_ST_REBOOT); // RL18
    end
  end
  // =====================================
  // outputs; nothing received is ever looped back to a transmitter
  assign o_frame_req = frame_req_ff; // RL11
  assign o_frame_rs232_en = (mode_ff != OMTC_NET); // RL9
  assign o_frame_rs422_en = (mode_ff != OMTC_NET); // RL9
  assign o_msg_req = msg_req_ff;
  assign o_msg_kind = msg_kind_ff;
  assign o_reset_cause = cause_ff; // RL5
  assign o_normal = in_run;
  assign o_mode = (in_init || st_ff == OMTC_ST_REBOOT) ? MODE_RESET : mode_ff;
  assign o_net_link_en = in_run && (mode_ff != OMTC_AUTO); // RL8
  assign o_console = (st_ff == OMTC_ST_CONSOLE); // RL6
  assign o_polled = polled_ff;
  assign o_sensor_pwr = pwr_ff;
  assign o_sys_reset = sys_reset_ff;
  // =====================================
  // checks
  chk_mode_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL1
    $onehot(mode_ff)) else $error("mode not one-hot");
  chk_init_len: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL2
    $rose(in_run) |-> $past(tmr_ff) == CNT_W'(INIT_CNT - 1)) else $error("init too short");
  chk_run_stays: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL3
    in_run && !c_rst && !c_con |=> in_run) else $error("left normal operation");
  chk_auto_net_off: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL8
    mode_ff == OMTC_AUTO |-> !o_net_link_en) else $error("net link on in autonomous");
  chk_poll_one: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL14
    poll_fire |=> o_frame_req ##1 !o_frame_req) else $error("poll frame count wrong");
  chk_pwr_mute: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL16
    !pwr_ff |=> !o_frame_req) else $error("frame while powered down");
  chk_poll_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL13
    polled_ff && !c_req |=> !o_frame_req) else $error("free frame in polled mode");
  chk_reboot_soft: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL18
    c_rst && in_run |=> st_ff == OMTC_ST_REBOOT ##1 soft_ff) else $error("reboot cause lost");
  chk_quiet_msg: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL7
    i_quiet && $stable(i_quiet) |-> !msg_req_ff) else $error("message while quiet");
  chk_console_stays: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL12
    o_console |=> o_console) else $error("console left without reset");
  chk_cause_soft: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL18
    $rose(in_init) && $past(st_ff) == OMTC_ST_REBOOT |=> o_reset_cause == CAUSE_SOFT)
    else $error("reboot cause not software");
  chk_mode_msg: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL7
    init_end && !i_quiet |=> o_msg_req && o_msg_kind == MSG_MODE) else $error("no mode message");
  chk_init_defaults: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RL24
    $rose(in_init) |-> o_sensor_pwr && !o_polled) else $error("sub-mode not back to default");
  cov_console: cover property (@(posedge i_clk) disable iff (!i_rst_b) c_con && in_init);
  cov_poll: cover property (@(posedge i_clk) disable iff (!i_rst_b) poll_fire);
  cov_master: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    init_end && mst_ok && !force_auto);
  cov_reboot: cover property (@(posedge i_clk) disable iff (!i_rst_b) c_rst);
  cov_free: cover property (@(posedge i_clk) disable iff (!i_rst_b) free_fire);
endmodule

// ==== dv/omtc_host.sv ====
`timescale 1ns/100ps
module omtc_host (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_frame_req,
  output logic o_frame_done
);
  // =====================================
  // frame sender on the telemetry side
  // slow mode keeps a frame busy long enough that queued polls must wait
  int frames = 0;
  int left = 0;
  always @(posedge i_clk) begin
    o_frame_done <= 1'b0;
    if (i_frame_req === 1'b1) begin
      frames <= frames + 1;
      left <= i_slow ? 30 : 3;
    end else if (left == 1) begin
      o_frame_done <= 1'b1;
      left <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule

// ==== dv/operating_mode_telemetry_control_test.sv ====
`timescale 1ns/100ps
module operating_mode_telemetry_control_test;
  import omtc_pkg::*;
  localparam int unsigned INIT_N = 50;
  localparam int unsigned BOOT_N = 20;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ext_reset_seen = 1'b0;
  logic i_quiet = 1'b0;
  logic i_net_en = 1'b0;
  logic i_master_en = 1'b0;
  logic i_bias_en = 1'b0;
  logic i_master_attached = 1'b0;
  logic i_slaves_attached = 1'b0;
  logic i_rs422_full_duplex = 1'b0;
  logic [CNT_W-1:0] i_frame_period = 32'h0000_000a;
  logic i_rs232_valid = 1'b0;
  logic [7:0] i_rs232_data = 8'h00;
  logic i_rs422_valid = 1'b0;
  logic [7:0] i_rs422_data = 8'h00;
  logic i_frame_done, slow = 1'b0;
  logic o_cmd_ready, o_frame_req, o_frame_rs232_en, o_frame_rs422_en, o_msg_req;
  logic [1:0] o_msg_kind, o_reset_cause;
  logic o_normal, o_net_link_en, o_console, o_polled, o_sensor_pwr, o_sys_reset;
  logic [2:0] o_mode;
  logic [1:0] kinds[$];
  logic [1:0] causes[$];
  int fails = 0;
  int num_checks = 0;
  int f0;
  always #5 i_clk = ~i_clk;
  omtc_top #(.INIT_CNT(INIT_N), .REBOOT_CNT(BOOT_N)) u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ext_reset_seen(i_ext_reset_seen),
    .i_quiet(i_quiet), .i_net_en(i_net_en), .i_master_en(i_master_en),
    .i_bias_en(i_bias_en), .i_master_attached(i_master_attached),
    .i_slaves_attached(i_slaves_attached), .i_rs422_full_duplex(i_rs422_full_duplex),
    .i_frame_period(i_frame_period), .i_rs232_valid(i_rs232_valid),
    .i_rs232_data(i_rs232_data), .i_rs422_valid(i_rs422_valid),
    .i_rs422_data(i_rs422_data), .o_cmd_ready(o_cmd_ready), .i_frame_done(i_frame_done),
    .o_frame_req(o_frame_req), .o_frame_rs232_en(o_frame_rs232_en),
    .o_frame_rs422_en(o_frame_rs422_en), .o_msg_req(o_msg_req), .o_msg_kind(o_msg_kind),
    .o_reset_cause(o_reset_cause), .o_normal(o_normal), .o_mode(o_mode),
    .o_net_link_en(o_net_link_en), .o_console(o_console), .o_polled(o_polled),
    .o_sensor_pwr(o_sensor_pwr), .o_sys_reset(o_sys_reset)
  );
  omtc_host u_host (.i_clk(i_clk), .i_slow(slow), .i_frame_req(o_frame_req),
    .o_frame_done(i_frame_done));
  always @(posedge i_clk) begin
    if (o_msg_req === 1'b1) begin
      kinds.push_back(o_msg_kind);
      causes.push_back(o_reset_cause);
    end
  end
  // =====================================
  // common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic rst_hold();
    i_rst_b = 1'b0;
    tick(3);
    kinds.delete();
    causes.delete();
    i_rst_b = 1'b1;
  endtask
  // bounded wait for normal operation, n counts cycles from entry into this task
  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (o_normal !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) begin
      fails++;
      end_sim();
    end
    check(n >= lo && n <= hi, 1);
  endtask
  task automatic boot();
    rst_hold();
    wait_run(INIT_N - 2, INIT_N + 3);
  endtask
  task automatic mode_msgs(input logic [1:0] cause, input logic [2:0] mode);
    tick(3);
    if (i_quiet) begin
      check(kinds.size(), 0);
    end else begin
      check(kinds.size(), 2);
      check(kinds[0], MSG_BANNER);
      check(causes[0], cause);
      check(kinds[1], MSG_MODE);
    end
    check(o_mode, mode);
    check(o_net_link_en, mode != OMTC_AUTO);
    check(o_frame_rs232_en, mode != OMTC_NET);
    check(o_frame_rs422_en, mode != OMTC_NET);
  endtask
  // the host speaks on rs232; rs422 only counts with full duplex
  task automatic send(input logic [7:0] b, input logic on422);
    if (on422) begin
      i_rs422_valid = 1'b1;
      i_rs422_data = b;
    end else begin
      i_rs232_valid = 1'b1;
      i_rs232_data = b;
    end
    tick(1);
    i_rs232_valid = 1'b0;
    i_rs422_valid = 1'b0;
    // a free frame in flight can hold the pop back by five cycles
    tick(7);
  endtask
  task automatic frames_in(input int n, input int lo, input int hi);
    f0 = u_host.frames;
    tick(n);
    check((u_host.frames - f0) >= lo && (u_host.frames - f0) <= hi, 1);
  endtask
  // =====================================
  // scenarios
  task automatic t_power_up();
    tick(2);
    check({o_sensor_pwr, o_polled, o_normal}, 3'b100);
    boot();
    mode_msgs(CAUSE_POWER, OMTC_AUTO);
    frames_in(200, 10, 21);
    check(o_normal, 1);
  endtask
  task automatic t_poll();
    send(CMD_POLL, 1'b0);
    check(o_polled, 1);
    f0 = u_host.frames;
    send(8'h55, 1'b0);
    send(CMD_POLL, 1'b0);
    tick(60);
    check(u_host.frames - f0, 0);
    check(o_polled, 1);
    slow = 1'b1;
    f0 = u_host.frames;
    send(CMD_ENTER, 1'b0);
    send(CMD_SPACE, 1'b0);
    tick(100);
    check(u_host.frames - f0, 2);
    slow = 1'b0;
    send(CMD_FREE, 1'b0);
    check(o_polled, 0);
  endtask
  task automatic t_power();
    send(CMD_PWR_DN, 1'b0);
    check(o_sensor_pwr, 0);
    send(CMD_POLL, 1'b0);
    send(CMD_PWR_DN, 1'b0);
    frames_in(100, 0, 0);
    send(CMD_PWR_UP, 1'b0);
    check({o_sensor_pwr, o_polled}, 2'b11);
    frames_in(50, 0, 0);
    f0 = u_host.frames;
    send(CMD_ENTER, 1'b0);
    tick(20);
    check(u_host.frames - f0, 1);
    send(CMD_FREE, 1'b0);
    frames_in(100, 1, 11);
  endtask
  task automatic t_rs422();
    send(CMD_POLL, 1'b1);
    check(o_polled, 0);
    i_rs422_full_duplex = 1'b1;
    send(CMD_POLL, 1'b1);
    check(o_polled, 1);
    send(CMD_FREE, 1'b1);
    i_rs422_full_duplex = 1'b0;
  endtask
  task automatic t_reboot_console();
    kinds.delete();
    causes.delete();
    send(CMD_RESET, 1'b0);
    check({o_sys_reset, o_normal}, 2'b10);
    wait_run(INIT_N + BOOT_N - 6, INIT_N + BOOT_N + 4);
    mode_msgs(CAUSE_SOFT, OMTC_AUTO);
    send(CMD_CONSOLE, 1'b0);
    check(o_console, 1);
    // console holds the queue, so unknown bytes pile up until refused
    repeat (16) send(8'h55, 1'b0);
    check({o_cmd_ready, o_console}, 2'b01);
  endtask
  task automatic t_network();
    {i_net_en, i_master_attached} = 2'b11;
    boot();
    mode_msgs(CAUSE_POWER, OMTC_NET);
    {i_master_en, i_bias_en, i_slaves_attached, i_ext_reset_seen} = 4'hf;
    boot();
    mode_msgs(CAUSE_EXT, OMTC_MASTER);
    {i_bias_en, i_quiet} = 2'b01;
    boot();
    mode_msgs(CAUSE_EXT, OMTC_NET);
    rst_hold();
    send(CMD_CONSOLE, 1'b0);
    check(o_console, 0);
    tick(INIT_N + 5);
    check({o_console, o_mode}, {1'b1, OMTC_AUTO});
  endtask
  initial begin
    t_power_up();
    t_poll();
    t_power();
    t_rs422();
    t_reboot_console();
    t_network();
    end_sim();
  end
endmodule
